//--- logic/cips_core.sv
// Interrupt pend, mask, acquire and end-of-service logic of one processor.
//
// Operation
// - Each local pin is edge or level, has a kind, and a vector.
// - Level mode applies only to external-kind local pins; init and platform kinds stay edge.
// - Platform pin pends platform vector 0; init pin pends an init.
// - Timer, monitor and corrected check each pend their own vector.
// - Each message names one destination; only ours is taken.
// - Pins, messages to us and internal events all set pending.
// - Edge external interrupts stay pending until acquired, then in-service.
// - Init and platform bits stay until firmware clears them.
// - Level pin pending follows the pin.
// - One init bit, one bit per vector; repeats merge.
// - Deliverable unmasked highest interrupt is taken by the processor.
// - Acquire read marks vector in-service and clears pending.
// - End-of-service write clears highest in-service bit.
// - Init needs check mask 0, platform collection 1, external enable 1.
// - Masking: above all in-service and above task priority class.
// - Init over platform over external; 2 over 0 over 255..16.
// - Vectors 16..255 form classes by bits 7:4, compared to mask.
// - Vector 15 is returned when nothing unmasked is pending.
`timescale 1ns/1ps
module cips_core
    import cips_pkg::*;
#(
    parameter int              NUM_PINS = 2,
    parameter logic [ID_W-1:0] CPU_ID   = 8'h00
)(
    input  wire logic            ref_clk_in,        // Processor clock.
    input  wire logic            nrst_in,           // Async reset, low.
    input  wire logic            wb_cyc_in,         // Bus cycle.
    input  wire logic            wb_stb_in,         // Bus strobe.
    input  wire logic            wb_we_in,          // Bus write.
    input  wire logic [7:0]      wb_adr_in,         // Byte address.
    input  wire logic [3:0]      wb_sel_in,         // Byte enables.
    input  wire logic [31:0]     wb_dat_in,         // Write data.
    output logic      [31:0]     wb_dat_out,        // Read data.
    output logic                 wb_ack_out,        // Acknowledge.
    input  wire cips_msg_s       bus_msg_in,        // Bus interrupt message.
    input  wire logic [NUM_PINS-1:0] local_irq_pin_in, // Local pins.
    input  wire logic            init_pin_in,       // Init pin.
    input  wire logic            pmi_pin_in,        // Platform pin.
    input  wire logic            timer_evt_in,      // Interval timer event.
    input  wire logic            perf_evt_in,       // Monitor event.
    input  wire logic            cmc_evt_in,        // Corrected check event.
    output logic                 take_init_out,     // Init taken.
    output logic                 take_pmi_out,      // Platform taken.
    output logic                 take_ext_out,      // External taken.
    output logic      [3:0]      pmi_vec_out        // Platform vector.
);

    function automatic logic [8:0] highest(input logic [NUM_VEC-1:0] b);
        logic [8:0] r;
        r = 9'h000;
        for (int i = VEC_GEN_MIN; i < NUM_VEC; i++) begin
            if (b[i]) r = {1'b1, 8'(i)};
        end
        if (b[VEC_LEGACY]) r = {1'b1, VEC_LEGACY};
        if (b[VEC_NMI]) r = {1'b1, VEC_NMI};
        return r;
    endfunction

    function automatic logic [8:0] rank(input logic [7:0] v);
        if (v == VEC_NMI) return 9'h101;
        if (v == VEC_LEGACY) return 9'h100;
        return {1'b0, v};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    logic [2:0]           enables;
    logic [4:0]           task_pri;
    cips_pin_cfg_s        pin_cfg [NUM_PINS];
    logic [7:0]           int_vec [3];
    logic [NUM_VEC-1:0]   ext_pend;
    logic [NUM_VEC-1:0]   in_svc;
    logic                 init_pend;
    logic [NUM_PMI-1:0]   pmi_pend;
    logic [NUM_PINS-1:0]  pin_q;
    logic                 init_q;
    logic                 pmi_q;

    logic [NUM_VEC-1:0]   ext_set;
    logic [NUM_VEC-1:0]   lvl_vec;
    logic [NUM_PMI-1:0]   pmi_set;
    logic                 init_set;
    logic [3:0]           pmi_low;
    logic [31:0]          rd_mux;

    wire                  req      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire                  wr       = req & wb_we_in;
    wire                  rd       = req & ~wb_we_in;
    wire                  msg_ours = bus_msg_in.valid &
                                     (bus_msg_in.dest == CPU_ID);
    wire [NUM_VEC-1:0]    ext_seen = ext_pend | lvl_vec;
    wire [8:0]            hp       = highest(ext_seen);
    wire [8:0]            his      = highest(in_svc);
    wire                  hp_found = hp[8];
    wire [7:0]            hp_vec   = hp[7:0];
    wire                  his_found = his[8];
    wire [7:0]            his_vec  = his[7:0];
    wire                  mmi      = task_pri[TP_MMI_BIT];
    wire [3:0]            mic      = task_pri[3:0];
    wire                  above_svc = ~his_found |
                                      (rank(hp_vec) > rank(his_vec));
    wire                  tpr_ok   = (hp_vec == VEC_NMI) | (~mmi &
                                     ((hp_vec == VEC_LEGACY) |
                                      (hp_vec[7:4] > mic)));
    wire                  unmasked = hp_found & above_svc & tpr_ok;
    wire [7:0]            acq_vec  = unmasked ? hp_vec : VEC_SPURIOUS;
    wire                  acq      = rd & (wb_adr_in == ADR_VEC_ACQ);
    wire                  eos      = wr & (wb_adr_in == ADR_END_SVC);
    wire                  fw_clr   = wr & (wb_adr_in == ADR_FW_CLEAR);
    wire [NUM_VEC-1:0]    acq_clr  = (acq & unmasked) ?
                                     (NUM_VEC'(1) << hp_vec) : '0;
    wire [NUM_VEC-1:0]    eos_clr  = (eos & his_found) ?
                                     (NUM_VEC'(1) << his_vec) : '0;
    wire [31:0]           fw_bits  = merge(32'h0, wb_dat_in, wb_sel_in);
    wire                  init_ok  = init_pend & ~enables[EN_MC_BIT];
    wire                  pmi_ok   = (|pmi_pend) & enables[EN_IC_BIT];
    wire                  ext_ok   = unmasked & enables[EN_I_BIT];

    // Next pending state: the set term is ORed last so new events survive.
    wire [NUM_VEC-1:0]    next_ext_pend = (ext_pend & ~acq_clr) | ext_set;
    wire [NUM_VEC-1:0]    next_in_svc   = (in_svc & ~eos_clr) | acq_clr;
    wire                  next_init     = (init_pend &
                                          ~(fw_clr & fw_bits[FW_INIT_BIT])) |
                                          init_set;
    wire [NUM_PMI-1:0]    next_pmi      = (pmi_pend &
                                          ~(fw_clr ? fw_bits[FW_PMI_LSB +: NUM_PMI]
                                                   : '0)) | pmi_set;

    // Collects every source that pends an interrupt in this cycle.
    always_comb begin
        ext_set  = '0;
        lvl_vec  = '0;
        pmi_set  = '0;
        init_set = 1'b0;
        if (msg_ours) begin
            case (bus_msg_in.kind)
                KIND_EXT:  ext_set[bus_msg_in.vector] = 1'b1;
                KIND_PMI:  pmi_set[bus_msg_in.vector[3:0]] = 1'b1;
                KIND_INIT: init_set = 1'b1;
                default:   ;
            endcase
        end
        for (int p = 0; p < NUM_PINS; p++) begin
            // Level mode only counts for external kinds; others stay edge.
            if (pin_cfg[p].level && pin_cfg[p].kind == KIND_EXT) begin
                if (local_irq_pin_in[p]) lvl_vec[pin_cfg[p].vector] = 1'b1;
            end else if (local_irq_pin_in[p] && !pin_q[p]) begin
                case (pin_cfg[p].kind)
                    KIND_EXT:  ext_set[pin_cfg[p].vector] = 1'b1;
                    KIND_PMI:  pmi_set[pin_cfg[p].vector[3:0]] = 1'b1;
                    KIND_INIT: init_set = 1'b1;
                    default:   ;
                endcase
            end
        end
        if (init_pin_in && !init_q) init_set = 1'b1;
        if (pmi_pin_in && !pmi_q) pmi_set[PMI_PIN_VEC] = 1'b1;
        if (timer_evt_in) ext_set[int_vec[0]] = 1'b1;
        if (perf_evt_in) ext_set[int_vec[1]] = 1'b1;
        if (cmc_evt_in) ext_set[int_vec[2]] = 1'b1;
    end

    // Lowest numbered pending platform vector is served first.
    always_comb begin
        pmi_low = 4'h0;
        for (int k = NUM_PMI - 1; k >= 0; k--) begin
            if (pmi_pend[k]) pmi_low = 4'(k);
        end
    end

    // Register read selection.
    always_comb begin
        rd_mux = 32'h0;
        case (wb_adr_in)
            ADR_ENABLES:   rd_mux = {29'h0, enables};
            ADR_TASK_PRI:  rd_mux = {27'h0, task_pri};
            ADR_VEC_ACQ:   rd_mux = {24'h0, acq_vec};
            ADR_STATUS:    rd_mux = {4'h0, pmi_low, his_vec,
                                     hp_found ? hp_vec : VEC_SPURIOUS,
                                     6'h0, |pmi_pend, init_pend};
            ADR_TIMER_VEC: rd_mux = {24'h0, int_vec[0]};
            ADR_PERF_VEC:  rd_mux = {24'h0, int_vec[1]};
            ADR_CMC_VEC:   rd_mux = {24'h0, int_vec[2]};
            default: begin
                for (int p = 0; p < NUM_PINS; p++) begin
                    if (wb_adr_in == ADR_PIN_CFG0 + 8'(4 * p))
                        rd_mux = {16'h0, pin_cfg[p].vector, 5'h0,
                                  pin_cfg[p].kind, pin_cfg[p].level};
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end else begin
            wb_ack_out <= req;
            wb_dat_out <= rd ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ext_pend  <= '0;
            in_svc    <= '0;
            init_pend <= 1'b0;
            pmi_pend  <= '0;
            pin_q     <= '0;
            init_q    <= 1'b0;
            pmi_q     <= 1'b0;
        end else begin
            ext_pend  <= next_ext_pend;
            in_svc    <= next_in_svc;
            init_pend <= next_init;
            pmi_pend  <= next_pmi;
            pin_q     <= local_irq_pin_in;
            init_q    <= init_pin_in;
            pmi_q     <= pmi_pin_in;
        end
    end

    // Software programmable state; unlisted addresses ignore writes.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enables  <= ENABLES_RST;
            task_pri <= TASK_PRI_RST;
            int_vec  <= '{INT_VEC_RST, INT_VEC_RST, INT_VEC_RST};
            for (int p = 0; p < NUM_PINS; p++) pin_cfg[p] <= PIN_CFG_RST;
        end else if (wr) begin
            case (wb_adr_in)
                ADR_ENABLES:   enables <= 3'(merge({29'h0, enables},
                                         wb_dat_in, wb_sel_in));
                ADR_TASK_PRI:  task_pri <= 5'(merge({27'h0, task_pri},
                                          wb_dat_in, wb_sel_in));
                ADR_TIMER_VEC: int_vec[0] <= 8'(merge({24'h0, int_vec[0]},
                                            wb_dat_in, wb_sel_in));
                ADR_PERF_VEC:  int_vec[1] <= 8'(merge({24'h0, int_vec[1]},
                                            wb_dat_in, wb_sel_in));
                ADR_CMC_VEC:   int_vec[2] <= 8'(merge({24'h0, int_vec[2]},
                                            wb_dat_in, wb_sel_in));
                default: begin
                    for (int p = 0; p < NUM_PINS; p++) begin
                        if (wb_adr_in == ADR_PIN_CFG0 + 8'(4 * p)) begin
                            if (wb_sel_in[0]) begin
                                pin_cfg[p].level <= wb_dat_in[0];
                                pin_cfg[p].kind <= cips_kind_e'(wb_dat_in[2:1]);
                            end
                            if (wb_sel_in[1])
                                pin_cfg[p].vector <= wb_dat_in[15:8];
                        end
                    end
                end
            endcase
        end
    end

    // Only the highest deliverable kind is signalled to the core.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            take_init_out <= 1'b0;
            take_pmi_out  <= 1'b0;
            take_ext_out  <= 1'b0;
            pmi_vec_out   <= 4'h0;
        end else begin
            take_init_out <= init_ok;
            take_pmi_out  <= pmi_ok & ~init_ok;
            take_ext_out  <= ext_ok & ~init_ok & ~pmi_ok;
            pmi_vec_out   <= pmi_low;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_acquire_hit;
        acq && unmasked;
    endsequence

    sequence s_acquire_miss;
        acq && !unmasked;
    endsequence

    a_msg_pends_vector: assert property (
        msg_ours && bus_msg_in.kind == KIND_EXT
        |=> ext_pend[$past(bus_msg_in.vector)])
        else $error("Message to this cpu did not pend its vector.");

    a_pmi_pin_vector: assert property (
        pmi_pin_in && !pmi_q |=> pmi_pend[PMI_PIN_VEC] ##1
        (pmi_pend[PMI_PIN_VEC] || $past(fw_clr && fw_bits[FW_PMI_LSB])))
        else $error("Platform pin did not pend vector zero.");

    a_acquire_in_service: assert property (
        s_acquire_hit |=> in_svc[$past(hp_vec)] && wb_ack_out &&
                          wb_dat_out == {24'h0, $past(hp_vec)})
        else $error("Acquire did not return and mark the vector.");

    a_acquire_clears: assert property (
        (s_acquire_hit and !ext_set[hp_vec]) |=> !ext_pend[$past(hp_vec)])
        else $error("Acquire left the pending bit set.");

    a_spurious_answer: assert property (
        s_acquire_miss |=> wb_dat_out == {24'h0, VEC_SPURIOUS} && wb_ack_out)
        else $error("Masked acquire did not return the spurious vector.");

    a_eos_clears_top: assert property (
        eos && his_found |=> !in_svc[$past(his_vec)])
        else $error("End of service left the top vector in service.");

    a_tpr_masks_class: assert property (
        hp_found && hp_vec >= 8'h10 && (mmi || hp_vec[7:4] <= mic)
        |-> !unmasked)
        else $error("Vector at or below the task class was unmasked.");

    a_init_precedence: assert property (
        init_pend && !enables[EN_MC_BIT]
        |=> take_init_out && !take_pmi_out && !take_ext_out)
        else $error("Deliverable init was not the only one taken.");

    a_ext_enable_gate: assert property (
        !enables[EN_I_BIT] |=> !take_ext_out)
        else $error("External taken while external enable was clear.");

    a_pend_survives_acq: assert property (
        (s_acquire_hit and ext_set[hp_vec]) |=> ext_pend[$past(hp_vec)])
        else $error("Pend in the acquire cycle was lost.");

endmodule // cips_core

//--- logic/cips_pkg.sv
// Constants, register map and carrier types of the interrupt pend and service block.
package cips_pkg;
    localparam int          ID_W            = 8;
    localparam int          NUM_VEC         = 256;
    localparam int          NUM_PMI         = 16;
    // Register word addresses on the bus (byte addresses).
    localparam logic [7:0]  ADR_ENABLES     = 8'h00;
    localparam logic [7:0]  ADR_TASK_PRI    = 8'h04;
    localparam logic [7:0]  ADR_VEC_ACQ     = 8'h08;
    localparam logic [7:0]  ADR_END_SVC     = 8'h0C;
    localparam logic [7:0]  ADR_STATUS      = 8'h10;
    localparam logic [7:0]  ADR_FW_CLEAR    = 8'h14;
    localparam logic [7:0]  ADR_TIMER_VEC   = 8'h18;
    localparam logic [7:0]  ADR_PERF_VEC    = 8'h1C;
    localparam logic [7:0]  ADR_CMC_VEC     = 8'h20;
    localparam logic [7:0]  ADR_PIN_CFG0    = 8'h40;
    // Field positions.
    localparam int          EN_MC_BIT       = 0;
    localparam int          EN_IC_BIT       = 1;
    localparam int          EN_I_BIT        = 2;
    localparam int          TP_MMI_BIT      = 4;
    localparam int          FW_INIT_BIT     = 0;
    localparam int          FW_PMI_LSB      = 16;
    localparam int          ST_PMI_ANY_BIT  = 1;
    localparam int          ST_HP_LSB       = 8;
    localparam int          ST_HIS_LSB      = 16;
    localparam int          ST_PMIV_LSB     = 24;
    // Reset values.
    localparam logic [2:0]  ENABLES_RST     = 3'h1;
    localparam logic [4:0]  TASK_PRI_RST    = 5'h10;
    localparam logic [7:0]  INT_VEC_RST     = 8'h0F;
    // Fixed vectors.
    localparam logic [7:0]  VEC_SPURIOUS    = 8'h0F;
    localparam logic [7:0]  VEC_NMI         = 8'h02;
    localparam logic [7:0]  VEC_LEGACY      = 8'h00;
    localparam logic [3:0]  PMI_PIN_VEC     = 4'h0;
    localparam int          VEC_GEN_MIN     = 16;

    typedef enum logic [1:0] {
        KIND_EXT  = 2'b00,
        KIND_PMI  = 2'b01,
        KIND_INIT = 2'b10
    } cips_kind_e;

    typedef struct packed {
        logic             valid;
        logic [ID_W-1:0]  dest;
        cips_kind_e       kind;
        logic [7:0]       vector;
    } cips_msg_s;

    typedef struct packed {
        logic [7:0]       vector;
        cips_kind_e       kind;
        logic             level;
    } cips_pin_cfg_s;

    localparam cips_pin_cfg_s PIN_CFG_RST = '{INT_VEC_RST, KIND_EXT, 1'b0};
endpackage

//--- bench/cips_src_model.sv
// Far-side interrupt source that turns request rising edges into bus messages.
`timescale 1ns/1ps
module cips_src_model
    import cips_pkg::*;
(
    input  wire logic            clk_in,   // Processor clock.
    input  wire logic            nrst_in,  // Async reset, low.
    input  wire logic            req_in,   // Source request level.
    input  wire logic [ID_W-1:0] dest_in,  // Target processor.
    input  wire logic [7:0]      vec_in,   // Vector to send.
    input  wire cips_kind_e      kind_in,  // Message kind.
    output cips_msg_s            msg_out   // Message to the bus.
);
    logic req_q;
    wire  edge_w = req_in & ~req_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_q   <= 1'b0;
            msg_out <= '0;
        end else begin
            req_q          <= req_in;
            msg_out.valid  <= edge_w;
            msg_out.kind   <= kind_in;
            // Outside a message dest and vector toggle so stale values never pass.
            msg_out.dest   <= edge_w ? dest_in : ~msg_out.dest;
            msg_out.vector <= edge_w ? vec_in : ~msg_out.vector;
        end
    end
endmodule // cips_src_model

//--- bench/testbench.sv
// Self-checking bench of the interrupt pend and service block.
`timescale 1ns/1ps
module testbench;
    import cips_pkg::*;
    logic ref_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, req = 0;
    logic init_pin = 0, pmi_pin = 0;
    logic [7:0] adr = 0, dst = 0, mv = 0, rv = 0;
    cips_kind_e knd = KIND_EXT;
    logic [31:0] wdat = 0, dat_o, rdat;
    logic [1:0] pins = 0;
    logic [2:0] evt = 0;
    logic ack, t_init, t_pmi, t_ext;
    logic [3:0] pvec;
    cips_msg_s msg;
    int n_errors = 0, checks = 0, seed = 32'h33ef, mic = 0, mmi = 1;
    bit pend[256], insvc[256];
    always #2 ref_clk = ~ref_clk;
    cips_src_model i_src(.clk_in(ref_clk), .nrst_in(nrst), .req_in(req),
        .dest_in(dst), .vec_in(mv), .kind_in(knd), .msg_out(msg));
    cips_core i_dut(.ref_clk_in(ref_clk), .nrst_in(nrst), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
        .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
        .bus_msg_in(msg), .local_irq_pin_in(pins), .init_pin_in(init_pin),
        .pmi_pin_in(pmi_pin), .timer_evt_in(evt[0]), .perf_evt_in(evt[1]),
        .cmc_evt_in(evt[2]), .take_init_out(t_init), .take_pmi_out(t_pmi),
        .take_ext_out(t_ext), .pmi_vec_out(pvec));
    task automatic end_sim();
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 0; stb <= 0;
    endtask
    function automatic int rk(int v);
        return v == 2 ? 258 : (v == 0 ? 257 : v);
    endfunction
    function automatic int top(bit b[256]);
        int h = -1;
        for (int v = 0; v < 256; v++)
            if (b[v] && (h < 0 || rk(v) > rk(h))) h = v;
        return h;
    endfunction
    function automatic int best();
        int hp = top(pend), hs = top(insvc);
        if (hp < 0) return 15;
        if (hs >= 0 && rk(hp) <= rk(hs)) return 15;
        if (hp != 2 && mmi) return 15;
        if (hp >= 16 && (hp >> 4) <= mic) return 15;
        return hp;
    endfunction
    task automatic acq();
        int e = best();
        wb(0, ADR_VEC_ACQ, 0);
        chk(rdat, e);
        if (e != 15) begin
            insvc[e] = 1;
            if (!(e == 8'h30 && pins[0])) pend[e] = 0;
        end
    endtask
    task automatic end_of_service_reg();
        int h = top(insvc);
        wb(1, ADR_END_SVC, 0);
        if (h >= 0) insvc[h] = 0;
    endtask
    task automatic send(input logic [7:0] d, input logic [7:0] v,
                        input cips_kind_e k = KIND_EXT);
        @(posedge ref_clk);
        req <= 1; dst <= d; mv <= v; knd <= k;
        repeat (3) @(posedge ref_clk);
        req <= 0;
        if (d == 0 && k == KIND_EXT) pend[v] = 1;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1;
        wb(0, ADR_ENABLES, 0);
        chk(rdat, 32'h1);
        wb(0, ADR_TASK_PRI, 0);
        chk(rdat, 32'h10);
        wb(0, 8'h3C, 0);
        chk(rdat, 32'h0);
        acq();
        wb(1, ADR_ENABLES, 32'h6);
        wb(1, ADR_TASK_PRI, 0);
        mmi = 0;
        send(8'h05, VEC_NMI);
        for (int i = 0; i < 4; i++) begin
            rv = 8'h10 + 8'($unsigned($random(seed)) % 240);
            send(0, rv);
            send(0, rv);
        end
        send(0, VEC_LEGACY);
        repeat (3) @(posedge ref_clk);
        chk(t_ext, 1);
        for (int i = 0; i < 8; i++) begin
            acq();
            if (i % 2) end_of_service_reg();
        end
        wb(1, ADR_TASK_PRI, 32'hF);
        mic = 15;
        for (int k = 0; k < 3; k++) begin
            wb(1, ADR_TIMER_VEC + 4 * k, 32'hF0 + k);
            @(posedge ref_clk);
            evt[k] <= 1;
            @(posedge ref_clk);
            evt[k] <= 0;
            pend[8'hF0 + k] = 1;
            acq();
        end
        wb(1, ADR_TASK_PRI, 0);
        mic = 0;
        repeat (4) begin acq(); end_of_service_reg(); end
        @(posedge ref_clk);
        evt[0] <= 1;
        @(posedge ref_clk);
        evt[0] <= 0;
        pend[8'hF0] = 1;
        // The second timer pulse lands on the edge that takes the acquire.
        fork
            acq();
            begin
                @(posedge ref_clk);
                evt[0] <= 1;
                @(posedge ref_clk);
                evt[0] <= 0;
            end
        join
        pend[8'hF0] = 1;
        end_of_service_reg();
        acq();
        end_of_service_reg();
        wb(1, ADR_PIN_CFG0, 32'h3001);
        wb(1, ADR_PIN_CFG0 + 4, 32'h5);
        pins <= 2'b11;
        pend[8'h30] = 1;
        repeat (3) @(posedge ref_clk);
        acq();
        pins <= 2'b00;
        pend[8'h30] = 0;
        repeat (3) @(posedge ref_clk);
        end_of_service_reg();
        acq();
        chk(t_init, 1);
        wb(1, ADR_FW_CLEAR, 32'h1);
        wb(0, ADR_STATUS, 0);
        chk(rdat[0], 0);
        init_pin <= 1;
        pmi_pin <= 1;
        repeat (3) @(posedge ref_clk);
        chk(t_init, 1);
        wb(1, ADR_FW_CLEAR, 32'h1);
        @(posedge ref_clk);
        chk({t_pmi, pvec}, 5'h10);
        wb(1, ADR_FW_CLEAR, 32'h10000);
        send(0, 8'h03, KIND_PMI);
        send(0, 8'h03, KIND_PMI);
        wb(0, ADR_STATUS, 0);
        chk({rdat[27:24], rdat[1:0]}, 6'h0E);
        chk({t_pmi, pvec}, 5'h13);
        send(0, 0, KIND_INIT);
        repeat (2) @(posedge ref_clk);
        chk(t_init, 1);
        wb(1, ADR_FW_CLEAR, 32'h80001);
        wb(0, ADR_STATUS, 0);
        chk(rdat[1:0], 0);
        end_sim();
    end
endmodule // testbench
